//--- verif/temp_monitor_smbus_slave_tb_top.sv
// Self-checking bench for the temperature monitor serial slave.
// Assumes design, header, host model and checker are compiled first.
`include "tms_defines.svh"
module temp_monitor_smbus_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, stby_n, rem_open, scl, host_low, sda_oe, sda_o, conv_start, conv_busy, alert_n;
   logic [7:0] loc_temp, rem_temp, rd;
   logic [3:0] acks;
   tms_pkg::tms_sel_t addr_sel;
   int err_total, checked, cycles, nstart;
   wire logic sda = !(host_low || (sda_oe && !sda_o));
   tms_slave u_dut (.CLK(clk), .SRST(srst), .SCL(scl), .SDA(sda), .SDA_DRV(sda_o),
      .SDA_OE(sda_oe), .ADDR_SEL(addr_sel), .STBY_N(stby_n), .LOC_TEMP(loc_temp),
      .REM_TEMP(rem_temp), .REM_OPEN(rem_open), .CONV_START(conv_start),
      .CONV_BUSY(conv_busy), .ALERT_N(alert_n));
   tms_host_bfm u_host (.scl(scl), .sda_low(host_low), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (conv_start === 1'b1) nstart <= nstart + 1;
      if (cycles == 80000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic [6:0] a, input logic r, input int n, input logic [23:0] d);
      u_host.frame(a, r, n, d, rd, acks);
      @(negedge clk);
   endtask
   task automatic wreg(input logic [7:0] p, input logic [7:0] v);
      bus(`TMS_ADDR_BASE, 1'b0, 2, {p, v, 8'h00});
   endtask
   task automatic rreg(input logic [7:0] p);
      bus(`TMS_ADDR_BASE, 1'b0, 1, {p, 16'h0000});
      bus(`TMS_ADDR_BASE, 1'b1, 1, 24'h000000);
   endtask
   task automatic wait_conv();
      repeat (2) begin
         wait (conv_busy === 1'b1);
         wait (conv_busy === 1'b0);
      end
      @(negedge clk);
   endtask
   task automatic t_addr();
      for (int i = 2; i >= 0; i--) begin
         @(negedge clk);
         srst = 1'b1;
         addr_sel = tms_pkg::tms_sel_t'(i);
         repeat (20) @(negedge clk);
         srst = 1'b0;
         repeat (60) @(negedge clk);
         addr_sel = tms_pkg::tms_sel_t'((i + 1) % 3);
         bus(`TMS_ADDR_BASE + 7'(i), 1'b1, 1, 24'h0);
         check("own address ack", 8'h01, {7'h0, acks[0]});
         check("read after reset", loc_temp, rd);
         bus(`TMS_ADDR_BASE + 7'((i + 1) % 3), 1'b0, 1, 24'h0);
         check("later select ignored", 8'h00, {7'h0, acks[0]});
      end
      $display("address test done");
   endtask
   task automatic t_limits();
      logic [7:0] vals [4] = '{8'h5a, 8'h85, 8'h6b, 8'h96};
      for (int k = 0; k < 4; k++) begin
         wreg(`TMS_PTR_LHI_WR + 8'(k), vals[k]);
         check("limit write acks", 8'h07, {5'h0, acks[2:0]});
         rreg(`TMS_PTR_LHI_RD + 8'(k));
         check("limit readback", vals[k], rd);
         bus(`TMS_ADDR_BASE, 1'b1, 1, 24'h0);
         check("pointer kept", vals[k], rd);
         rreg(`TMS_PTR_LHI_WR + 8'(k));
         check("write pointer hides value", 8'hff, rd);
      end
      bus(`TMS_ADDR_BASE, 1'b0, 3, {`TMS_PTR_CFG_WR, 8'h00, 8'h55});
      check("third byte refused", 8'h00, {7'h0, acks[3]});
      $display("limit test done");
   endtask
   task automatic t_alarm();
      wreg(`TMS_PTR_LHI_WR, 8'h05);
      wreg(`TMS_PTR_LLO_WR, 8'h05);
      loc_temp = 8'h05;
      wait_conv();
      rreg(`TMS_PTR_STATUS);
      rreg(`TMS_PTR_STATUS);
      check("equal limits quiet", 8'h00, rd & 8'h60);
      loc_temp = 8'hf0;
      wait_conv();
      rreg(`TMS_PTR_STATUS);
      check("signed low trip", 8'h20, rd & 8'h60);
      check("alert low", 8'h00, {7'h0, alert_n});
      loc_temp = 8'h06;
      wait_conv();
      rreg(`TMS_PTR_STATUS);
      rreg(`TMS_PTR_STATUS);
      check("high trip", 8'h40, rd & 8'h60);
      $display("alarm test done");
   endtask
   task automatic t_oneshot();
      int n0;
      wreg(`TMS_PTR_CFG_WR, 8'h40);
      repeat (100) @(negedge clk);
      n0 = nstart;
      repeat (400) @(negedge clk);
      check("standby holds", 8'h00, 8'(nstart - n0));
      wreg(`TMS_PTR_ONESHOT, 8'ha5);
      repeat (200) @(negedge clk);
      check("one shot count", 8'h01, 8'(nstart - n0));
      rreg(`TMS_PTR_CFG_RD);
      check("one shot data dropped", 8'h40, rd);
      wreg(`TMS_PTR_CFG_WR, 8'h00);
      stby_n = 1'b0;
      repeat (100) @(negedge clk);
      n0 = nstart;
      repeat (300) @(negedge clk);
      check("pin standby holds", 8'h00, 8'(nstart - n0));
      stby_n = 1'b1;
      $display("one shot test done");
   endtask
   initial begin
      srst = 1'b1;
      stby_n = 1'b1;
      rem_open = 1'b0;
      loc_temp = 8'h19;
      rem_temp = 8'h19;
      addr_sel = tms_pkg::TMS_SEL_LOW;
      t_addr();
      t_limits();
      t_alarm();
      t_oneshot();
      results();
   end
endmodule

//--- verif/tms_checker.sv
// Port-level assertions for the temperature monitor serial slave.
// Assumes one CLK domain with synchronous active-high SRST; bound to tms_slave.
module tms_checker (
   input wire logic CLK, // Clock
   input wire logic SRST, // Reset
   input wire logic SCL, // Bus clock pin
   input wire logic SDA, // Bus data pin
   input wire logic SDA_DRV, // Data drive value
   input wire logic SDA_OE, // Data pull enable
   input wire tms_pkg::tms_sel_t ADDR_SEL, // Address select
   input wire logic STBY_N, // Standby pin
   input wire logic [7:0] LOC_TEMP, // Local temperature
   input wire logic [7:0] REM_TEMP, // Remote temperature
   input wire logic REM_OPEN, // Open sensor
   input wire logic CONV_START, // Conversion start pulse
   input wire logic CONV_BUSY, // Conversion busy
   input wire logic ALERT_N // Alarm output
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] quiet_ff;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);
   // Counts cycles of pin standby with an idle bus; saturates
   always_ff @(posedge CLK) begin
      if (SRST || STBY_N || !SCL) begin
         quiet_ff <= 8'h00;
      end else if (quiet_ff != 8'hff) begin
         quiet_ff <= quiet_ff + 8'h01;
      end
   end
   property p_oe_low;
      SDA_OE |-> SDA_DRV == 1'b0;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("data driven high");
   property p_rst_quiet;
      $past(SRST) |-> !SDA_OE && ALERT_N;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
   property p_start_pulse;
      CONV_START |=> !CONV_START;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_busy_cause;
      $rose(CONV_BUSY) |-> CONV_START || $past(CONV_START);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
   property p_start_busy;
      CONV_START |-> ##[0:1] CONV_BUSY;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start without busy");
   property p_stop_release;
      $past(SCL) && SCL && $rose(SDA) |-> !SDA_OE [*8];
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("drive after stop");
   property p_oe_bounded;
      SDA_OE |-> ##[1:100] !SDA_OE;
   endproperty
   a_oe_bounded: assert property (p_oe_bounded) else $error("data held low");
   property p_stby_quiet;
      quiet_ff >= 8'h64 |-> !CONV_START;
   endproperty
   a_stby_quiet: assert property (p_stby_quiet) else $error("start in standby");
   property p_scl_low;
      $changed(SDA_OE) |-> !SCL;
   endproperty
   a_scl_low: assert property (p_scl_low) else $error("data moved, clock high");
endmodule

bind tms_slave tms_checker u_chk (.CLK(CLK), .SRST(SRST), .SCL(SCL), .SDA(SDA),
   .SDA_DRV(SDA_DRV), .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL), .STBY_N(STBY_N),
   .LOC_TEMP(LOC_TEMP), .REM_TEMP(REM_TEMP), .REM_OPEN(REM_OPEN),
   .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY), .ALERT_N(ALERT_N));

//--- verif/tms_host_bfm.sv
// Bus host model: drives the serial clock, pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up.
module tms_host_bfm (
   output logic scl, // Serial clock, high outside frames
   output logic sda_low, // High while the host pulls data low
   input wire logic sda // Resolved data level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Low phase is stretched so the slave's synchronised drive settles before the rise
   task automatic put_bit(input logic b, output logic got);
      #40 sda_low = !b;
      #100 scl = 1'b1;
      #60 got = sda;
      scl = 1'b0;
   endtask
   task automatic frame(input logic [6:0] addr, input logic rd, input int n,
      input logic [23:0] d, output logic [7:0] rdata, output logic [3:0] acks);
      logic [7:0] tx;
      logic got;
      acks = 4'h0;
      rdata = 8'h00;
      #100 sda_low = 1'b1;
      #100 scl = 1'b0;
      for (int k = 0; k <= n; k++) begin
         tx = (k == 0) ? {addr, rd} : d[31 - 8 * k -: 8];
         for (int i = 7; i >= 0; i--) begin
            put_bit((k > 0 && rd) ? 1'b1 : tx[i], got);
            if (k > 0) begin
               rdata[i] = got;
            end
         end
         put_bit(1'b1, got);
         acks[k] = !got;
      end
      #40 sda_low = 1'b1;
      #100 scl = 1'b1;
      #100 sda_low = 1'b0;
      #100;
   endtask
endmodule

//--- verilog/tms_defines.svh
// Constants for the temperature monitor serial slave.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH
`define TMS_ADDR_BASE 7'h4c
`define TMS_PTR_LOC_TEMP 8'h00
`define TMS_PTR_REM_TEMP 8'h01
`define TMS_PTR_STATUS 8'h02
`define TMS_PTR_CFG_RD 8'h03
`define TMS_PTR_RATE_RD 8'h04
`define TMS_PTR_LHI_RD 8'h05
`define TMS_PTR_LLO_RD 8'h06
`define TMS_PTR_RHI_RD 8'h07
`define TMS_PTR_RLO_RD 8'h08
`define TMS_PTR_CFG_WR 8'h09
`define TMS_PTR_RATE_WR 8'h0a
`define TMS_PTR_LHI_WR 8'h0b
`define TMS_PTR_LLO_WR 8'h0c
`define TMS_PTR_RHI_WR 8'h0d
`define TMS_PTR_RLO_WR 8'h0e
`define TMS_PTR_ONESHOT 8'h0f
`define TMS_PTR_MFR_ID 8'hfe
`define TMS_PTR_REV 8'hff
`define TMS_RST_PTR 8'h00
`define TMS_RST_CFG 8'h00
`define TMS_RST_RATE 8'h02
`define TMS_RST_HI 8'h7f
`define TMS_RST_LO 8'hc9
`define TMS_CFG_STANDBY_BIT 6
`define TMS_CFG_MASK_BIT 7
`define TMS_ST_BUSY_BIT 7
`define TMS_ST_LHI_BIT 6
`define TMS_ST_LLO_BIT 5
`define TMS_ST_RHI_BIT 4
`define TMS_ST_RLO_BIT 3
`define TMS_CONV_CYCLES 16'd40
`endif

//--- verilog/tms_pkg.sv
// Types for the temperature monitor serial slave.
// Assumes the defines header is compiled alongside.
package tms_pkg;
   typedef enum logic [2:0] {
      TMS_IDLE = 3'b000,
      TMS_ADDR = 3'b001,
      TMS_AACK = 3'b011,
      TMS_WBYTE = 3'b010,
      TMS_WACK = 3'b110,
      TMS_RBYTE = 3'b111,
      TMS_RACK = 3'b101,
      TMS_WAIT = 3'b100
   } tms_state_t;

   typedef enum logic [1:0] {
      TMS_SEL_LOW = 2'b00,
      TMS_SEL_OPEN = 2'b01,
      TMS_SEL_HIGH = 2'b10
   } tms_sel_t;

   typedef struct packed {
      logic [7:0] loc_hi;
      logic [7:0] loc_lo;
      logic [7:0] rem_hi;
      logic [7:0] rem_lo;
   } tms_limits_t;

   typedef struct packed {
      logic loc_hi;
      logic loc_lo;
      logic rem_hi;
      logic rem_lo;
   } tms_trip_t;
endpackage

//--- verilog/tms_slave.sv
// Serial bus slave with register file and limit comparators of a
// two-channel temperature monitor.
// Assumes bus clock and data are sampled from outside the CLK domain,
// and temperatures arrive from a converter front end on CLK.
// Function
// - High alarm only when temperature exceeds limit
// - Low alarm only when temperature below limit
// - Four limits writable and read back unchanged
// - One-shot in standby does one cycle, returns
// - One-shot triggered by write, data discarded
// - Three-level select picks one of three addresses
// - Select captured once after power-up only
// - Start then 7-bit address MSB first, direction
// - Acknowledge own address before ninth clock pulse
// - Direction bit zero writes, one reads
// - Nine clocks per byte, slave acks writes
// - Data changes only while clock is low
// - Data rising while clock high ends transfer
// - Direction fixed for whole transfer
// - Writes one or two bytes, reads one
// - First written byte loads register pointer
// - Second written byte stored at pointer
// - Read returns register at current pointer
// - Write pointers distinct from read pointers
// - Pointer is zero after power-up
// - One-shot responds to pointer location 0f
// - Tripped comparison sets its status flag
`include "tms_defines.svh"

module tms_slave #(
   parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] DIE_REV = 8'h01, // Arbitrary value
   parameter logic [15:0] CONV_CYCLES = `TMS_CONV_CYCLES
) (
   input wire logic CLK, // 40 MHz clock
   input wire logic SRST, // Synchronous reset, power-up
   input wire logic SCL, // Bus clock level
   input wire logic SDA, // Bus data level
   output logic SDA_DRV, // Data drive value, always low
   output logic SDA_OE, // High while pulling data low
   input wire tms_pkg::tms_sel_t ADDR_SEL, // Three-level address select
   input wire logic STBY_N, // Standby pin, low for standby
   input wire logic [7:0] LOC_TEMP, // Local temperature from converter
   input wire logic [7:0] REM_TEMP, // Remote temperature from converter
   input wire logic REM_OPEN, // Remote sensor open-circuit
   output logic CONV_START, // One-cycle pulse, starts conversion
   output logic CONV_BUSY, // Conversion cycle in progress
   output logic ALERT_N // Alarm, low while any flag is set and config bit 7 is clear
);
   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   tms_pkg::tms_sel_t sel_m_ff, sel_s_ff;
   logic stby_m_ff, stby_s_ff;
   logic [6:0] own_addr_ff;
   logic sel_taken_ff;
   tms_pkg::tms_state_t state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic rd_ff;
   logic [1:0] byte_cnt_ff;
   logic [7:0] ptr_ff;
   logic [7:0] cfg_ff;
   logic [7:0] rate_ff;
   tms_pkg::tms_limits_t lim_ff;
   logic [7:0] loc_val_ff, rem_val_ff;
   tms_pkg::tms_trip_t flag_ff;
   logic open_ff;
   logic oneshot_ff;
   logic oneshot_pend_ff;
   logic [15:0] conv_cnt_ff;
   logic conv_tick_ff;
   logic [7:0] rd_data;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic wr_strobe;
   logic status_read;
   logic standby;
   tms_pkg::tms_trip_t trip;

   // Signed compare, used by all four comparators
   function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
      return $signed(a) > $signed(b);
   endfunction

   always_ff @(posedge CLK) begin
      scl_m_ff <= SCL;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= SDA;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
   end

   // Strap and standby pins are asynchronous too; logic reads only the second stage
   always_ff @(posedge CLK) begin
      sel_m_ff <= ADDR_SEL;
      sel_s_ff <= sel_m_ff;
      stby_m_ff <= STBY_N;
      stby_s_ff <= stby_m_ff;
   end

   assign scl_rise = scl_s_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s_ff & scl_d_ff;
   assign start_det = scl_s_ff & scl_d_ff & ~sda_s_ff & sda_d_ff;
   assign stop_det = scl_s_ff & scl_d_ff & sda_s_ff & ~sda_d_ff;

   // Pin is caught on the first cycle after reset release, then frozen
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sel_taken_ff <= 1'b0;
         own_addr_ff <= `TMS_ADDR_BASE;
      end else if (!sel_taken_ff) begin
         sel_taken_ff <= 1'b1;
         unique case (sel_s_ff)
            tms_pkg::TMS_SEL_LOW: own_addr_ff <= `TMS_ADDR_BASE;
            tms_pkg::TMS_SEL_OPEN: own_addr_ff <= `TMS_ADDR_BASE + 7'h01;
            tms_pkg::TMS_SEL_HIGH: own_addr_ff <= `TMS_ADDR_BASE + 7'h02;
            default: own_addr_ff <= `TMS_ADDR_BASE + 7'h01;
         endcase
      end
   end

   // Byte engine: bits sampled on SCL rise, drive changed on SCL fall
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_ff <= tms_pkg::TMS_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rd_ff <= 1'b0;
         byte_cnt_ff <= 2'd0;
      end else if (start_det) begin
         state_ff <= tms_pkg::TMS_ADDR;
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 2'd0;
      end else if (stop_det) begin
         state_ff <= tms_pkg::TMS_IDLE;
      end else begin
         unique case (state_ff)
            tms_pkg::TMS_IDLE, tms_pkg::TMS_WAIT: ;
            tms_pkg::TMS_ADDR: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_s_ff};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                  bit_cnt_ff <= 4'h0;
                  if (shift_ff[7:1] == own_addr_ff) begin
                     state_ff <= tms_pkg::TMS_AACK;
                     rd_ff <= shift_ff[0];
                  end else begin
                     state_ff <= tms_pkg::TMS_WAIT;
                  end
               end
            end
            tms_pkg::TMS_AACK: begin
               if (scl_fall) begin
                  if (rd_ff) begin
                     state_ff <= tms_pkg::TMS_RBYTE;
                     shift_ff <= rd_data;
                  end else begin
                     state_ff <= tms_pkg::TMS_WBYTE;
                  end
               end
            end
            tms_pkg::TMS_WBYTE: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_s_ff};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                  bit_cnt_ff <= 4'h0;
                  // Third and later bytes are not acknowledged
                  if (byte_cnt_ff < 2'd2) begin
                     state_ff <= tms_pkg::TMS_WACK;
                     byte_cnt_ff <= byte_cnt_ff + 2'd1;
                  end else begin
                     state_ff <= tms_pkg::TMS_WAIT;
                  end
               end
            end
            tms_pkg::TMS_WACK: begin
               if (scl_fall) begin
                  state_ff <= tms_pkg::TMS_WBYTE;
               end
            end
            tms_pkg::TMS_RBYTE: begin
               if (scl_fall) begin
                  shift_ff <= {shift_ff[6:0], 1'b1};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff == 4'h7) begin
                     state_ff <= tms_pkg::TMS_RACK;
                     bit_cnt_ff <= 4'h0;
                  end
               end
            end
            tms_pkg::TMS_RACK: begin
               // One byte per read; the master's no-ack then stop follows
               if (scl_fall) begin
                  state_ff <= tms_pkg::TMS_WAIT;
               end
            end
            default: state_ff <= tms_pkg::TMS_IDLE;
         endcase
      end
   end

   // Open drain: drive low for ack slots and zero read bits
   always_ff @(posedge CLK) begin
      if (SRST) begin
         SDA_OE <= 1'b0;
      end else begin
         SDA_OE <= (state_ff == tms_pkg::TMS_AACK) || (state_ff == tms_pkg::TMS_WACK) ||
                   ((state_ff == tms_pkg::TMS_RBYTE) && !shift_ff[7]);
      end
   end
   assign SDA_DRV = 1'b0;

   assign wr_strobe = (state_ff == tms_pkg::TMS_WACK) && scl_fall;
   assign status_read = (state_ff == tms_pkg::TMS_AACK) && scl_fall && rd_ff &&
                        (ptr_ff == `TMS_PTR_STATUS);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ptr_ff <= `TMS_RST_PTR;
      end else if (wr_strobe && byte_cnt_ff == 2'd1) begin
         ptr_ff <= shift_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         cfg_ff <= `TMS_RST_CFG;
         rate_ff <= `TMS_RST_RATE;
         lim_ff <= {`TMS_RST_HI, `TMS_RST_LO, `TMS_RST_HI, `TMS_RST_LO};
      end else if (wr_strobe && byte_cnt_ff == 2'd2) begin
         unique case (ptr_ff)
            `TMS_PTR_CFG_WR: cfg_ff <= shift_ff;
            `TMS_PTR_RATE_WR: rate_ff <= shift_ff;
            `TMS_PTR_LHI_WR: lim_ff.loc_hi <= shift_ff;
            `TMS_PTR_LLO_WR: lim_ff.loc_lo <= shift_ff;
            `TMS_PTR_RHI_WR: lim_ff.rem_hi <= shift_ff;
            `TMS_PTR_RLO_WR: lim_ff.rem_lo <= shift_ff;
            default: ;
         endcase
      end
   end

   // Data byte is thrown away; only the access itself counts
   always_ff @(posedge CLK) begin
      if (SRST) begin
         oneshot_ff <= 1'b0;
      end else begin
         oneshot_ff <= wr_strobe && byte_cnt_ff == 2'd2 &&
                       ptr_ff == `TMS_PTR_ONESHOT;
      end
   end

   always_comb begin
      unique case (ptr_ff)
         `TMS_PTR_LOC_TEMP: rd_data = loc_val_ff;
         `TMS_PTR_REM_TEMP: rd_data = rem_val_ff;
         `TMS_PTR_STATUS: rd_data = {CONV_BUSY, flag_ff, open_ff, 2'b00};
         `TMS_PTR_CFG_RD: rd_data = cfg_ff;
         `TMS_PTR_RATE_RD: rd_data = rate_ff;
         `TMS_PTR_LHI_RD: rd_data = lim_ff.loc_hi;
         `TMS_PTR_LLO_RD: rd_data = lim_ff.loc_lo;
         `TMS_PTR_RHI_RD: rd_data = lim_ff.rem_hi;
         `TMS_PTR_RLO_RD: rd_data = lim_ff.rem_lo;
         `TMS_PTR_MFR_ID: rd_data = MFR_ID;
         `TMS_PTR_REV: rd_data = DIE_REV;
         default: rd_data = 8'hff;
      endcase
   end

   // Conversion scheduler; rate coding is left to the front end
   assign standby = cfg_ff[`TMS_CFG_STANDBY_BIT] | ~stby_s_ff;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         conv_cnt_ff <= 16'h0000;
         CONV_BUSY <= 1'b0;
         CONV_START <= 1'b0;
         conv_tick_ff <= 1'b0;
      end else begin
         conv_tick_ff <= 1'b0;
         CONV_START <= 1'b0;
         if (CONV_BUSY) begin
            if (conv_cnt_ff == CONV_CYCLES - 16'h0001) begin
               CONV_BUSY <= 1'b0;
               conv_tick_ff <= 1'b1;
            end
            conv_cnt_ff <= conv_cnt_ff + 16'h0001;
         end else if (!standby || oneshot_pend_ff) begin
            CONV_BUSY <= 1'b1;
            CONV_START <= 1'b1;
            conv_cnt_ff <= 16'h0000;
         end
      end
   end

   // A one-shot that lands while a conversion still runs waits for it to end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         oneshot_pend_ff <= 1'b0;
      end else if (oneshot_ff) begin
         oneshot_pend_ff <= 1'b1;
      end else if (CONV_START) begin
         oneshot_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         loc_val_ff <= 8'h00;
         rem_val_ff <= 8'h00;
         open_ff <= 1'b0;
      end else if (conv_tick_ff) begin
         loc_val_ff <= LOC_TEMP;
         rem_val_ff <= REM_TEMP;
         open_ff <= REM_OPEN | (open_ff & ~status_read);
      end else if (status_read && !REM_OPEN) begin
         open_ff <= 1'b0;
      end
   end

   assign trip.loc_hi = sgt(loc_val_ff, lim_ff.loc_hi);
   assign trip.loc_lo = sgt(lim_ff.loc_lo, loc_val_ff);
   assign trip.rem_hi = sgt(rem_val_ff, lim_ff.rem_hi);
   assign trip.rem_lo = sgt(lim_ff.rem_lo, rem_val_ff);

   // A live trip keeps its flag set even across a status read
   always_ff @(posedge CLK) begin
      if (SRST) begin
         flag_ff <= '0;
      end else if (status_read) begin
         flag_ff <= trip;
      end else begin
         flag_ff <= flag_ff | trip;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ALERT_N <= 1'b1;
      end else begin
         ALERT_N <= ~((|flag_ff | open_ff) & ~cfg_ff[`TMS_CFG_MASK_BIT]);
      end
   end
endmodule
